// [include/lcdh_if.sv]
// Pin-level link between the microcontroller and the display controller
`timescale 1ns/100ps
`default_nettype none
interface lcdh_if;
  logic [1:0] mode;
  logic       chip_select_active_low;
  logic       chip_select_active_high;
  logic       dc;
  logic       rw_wr;
  logic       e_rd;
  logic [7:0] host_d;
  logic       host_d_oe;
  logic [7:0] dev_d;
  logic       dev_d_oe;
  logic [7:0] bus_d;

  // Resolved data lines, pulled high when nobody drives
  assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 8'hFF);

  modport host (
    output mode, chip_select_active_low, chip_select_active_high,
    output dc, rw_wr, e_rd, host_d, host_d_oe,
    input  bus_d
  );
  modport dev (
    input  mode, chip_select_active_low, chip_select_active_high,
    input  dc, rw_wr, e_rd, bus_d,
    output dev_d, dev_d_oe
  );
endinterface : lcdh_if
`default_nettype wire

// [include/lcdh_pkg.sv]
// Shared constants and types for the display host port
package lcdh_pkg;

  // ---------------------------------------------------------------
  // Display memory geometry
  // ---------------------------------------------------------------
  localparam int         LCDH_COLS    = 132;
  localparam int         LCDH_PAGES   = 9;
  localparam int         LCDH_ROWS    = 65;
  localparam int         LCDH_MUX_POR = 64;
  localparam logic [6:0] LCDH_ICON_ROW = 7'h40;
  localparam logic [7:0] LCDH_COL_LAST = 8'h83;
  localparam logic [3:0] LCDH_PAGE_MAX = 4'h8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LCDH_COL_RST   = 8'h00;
  localparam logic [3:0] LCDH_PAGE_RST  = 4'h0;
  localparam logic [5:0] LCDH_START_RST = 6'h00;

  // ---------------------------------------------------------------
  // Command patterns
  // ---------------------------------------------------------------
  localparam logic [7:0] LCDH_CMD_COL_LO  = 8'h0?;
  localparam logic [7:0] LCDH_CMD_COL_HI  = 8'h1?;
  localparam logic [7:0] LCDH_CMD_START   = 8'b01??_????;
  localparam logic [7:0] LCDH_CMD_SEG_MAP = 8'b1010_000?;
  localparam logic [7:0] LCDH_CMD_REVERSE = 8'b1010_011?;
  localparam logic [7:0] LCDH_CMD_DISP_ON = 8'b1010_111?;
  localparam logic [7:0] LCDH_CMD_PAGE    = 8'hB?;
  localparam logic [7:0] LCDH_CMD_COM_DIR = 8'hC?;
  localparam logic [7:0] LCDH_CMD_RMW     = 8'hE0;
  localparam logic [7:0] LCDH_CMD_SW_RST  = 8'hE2;
  localparam logic [7:0] LCDH_CMD_RMW_END = 8'hEE;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int LCDH_MCLK_MHZ   = 200;
  localparam int LCDH_STROBE_NS  = 60;
  localparam int LCDH_STROBE_CYC = (LCDH_STROBE_NS * LCDH_MCLK_MHZ + 999) / 1000;
  localparam int LCDH_SCK_NS     = 64;
  localparam int LCDH_SCK_HALF   = (LCDH_SCK_NS * LCDH_MCLK_MHZ + 1999) / 2000;
  localparam int LCDH_CONV_DIV_W = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCDH_M6800 = 2'h0,
    LCDH_M8080 = 2'h1,
    LCDH_MSER  = 2'h2
  } lcdh_mode_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       csl;
    logic       csh;
    logic       dc;
    logic       rw;
    logic       e;
    logic [7:0] d;
  } lcdh_pins_t;

endpackage : lcdh_pkg

// [rtl/lcdh_dev.sv]
// Display controller end: host port, command decoder, display memory, scan
//
// Summary of operation
// - Data select high writes byte to RAM
// - Data select low decodes byte as command
// - 6800 read line high selects a read
// - 6800 read line low selects a write
// - 6800 enable latches while both selects active
// - Host issues dummy read before the first RAM read after reset or a write
// - 8080 read strobe drives data while low, latches on rising edge
// - 8080 data select picks RAM or status
// - 8080 write strobe latches on rising edge
// - 8080 host also issues dummy read
// - Serial shifts MSB first on clock rise
// - Eighth serial clock samples select, routes byte
// - Serial clock on line six, data seven
// - Display RAM is 132 by 65 bits
// - Start line register scrolls displayed rows
// - Segment and common mapping reversible independently
// - Own clock drives converter and scan timing
// - Rows beyond multiplex ratio show non-select, except the icon row
// - Reset clears shifter, column and page
// - Read-modify-write freezes column on reads, restores on exit
`timescale 1ns/100ps
`default_nettype none
module lcdh_dev
  import lcdh_pkg::*;
#(
  parameter int MUX_RATIO = LCDH_MUX_POR
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  lcdh_if.dev       bus,
  output logic [7:0] o_seg_col,
  output logic       o_seg_bit,
  output logic [6:0] o_com_row,
  output logic       o_com_nonsel,
  output logic       o_frame,
  output logic       o_conv_clk,
  output logic       o_rmw
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    lcdh_pins_t                 s1;
    lcdh_pins_t                 s2;
    lcdh_pins_t                 s3;
    logic [7:0]                 sh;
    logic [2:0]                 bitcnt;
    logic [3:0]                 page;
    logic [7:0]                 col;
    logic [7:0]                 col_save;
    logic                       rmw;
    logic [5:0]                 start;
    logic                       seg_remap;
    logic                       com_remap;
    logic                       disp_on;
    logic                       reverse;
    logic [7:0]                 rd_lat;
    logic [7:0]                 d_out;
    logic                       d_oe;
    logic [7:0]                 scan_col;
    logic [6:0]                 scan_row;
    logic [7:0]                 seg_col;
    logic                       seg_bit;
    logic [6:0]                 com_row;
    logic                       com_nonsel;
    logic                       frame;
    logic [LCDH_CONV_DIV_W-1:0] div;
  } lcdh_dev_t;

  lcdh_dev_t   r;
  lcdh_dev_t   next_r;
  logic [7:0]  ram [LCDH_COLS*LCDH_PAGES];
  logic        wr_en;
  logic [10:0] wr_a;
  logic [7:0]  wr_data;
  lcdh_pins_t  pins;
  logic        sel_now;
  logic        sel_prv;
  logic        rd_done;
  logic        byte_ok;
  logic        byte_dc;
  logic [7:0]  byte_v;
  logic [6:0]  row_map;
  logic [6:0]  ram_row;
  logic [7:0]  ram_col;
  logic [7:0]  scan_byte;

  function automatic logic [10:0] ram_idx(input logic [3:0] pg, input logic [7:0] c);
    ram_idx = 11'(11'(pg) * 11'(LCDH_COLS) + 11'(c));
  endfunction : ram_idx

  function automatic logic [7:0] col_inc(input logic [7:0] c);
    col_inc = (c >= LCDH_COL_LAST) ? LCDH_COL_RST : 8'(c + 8'h01);
  endfunction : col_inc

  always_comb begin
    pins.mode = bus.mode;
    pins.csl  = bus.chip_select_active_low;
    pins.csh  = bus.chip_select_active_high;
    pins.dc   = bus.dc;
    pins.rw   = bus.rw_wr;
    pins.e    = bus.e_rd;
    pins.d    = bus.bus_d;
  end

  // ---------------------------------------------------------------
  // Scan addressing
  // ---------------------------------------------------------------
  always_comb begin
    row_map = r.scan_row;
    if (r.com_remap && r.scan_row < 7'(MUX_RATIO)) begin
      row_map = 7'(7'(MUX_RATIO) - 7'h01 - r.scan_row);
    end
    // start line offset, icon row fixed
    if (r.scan_row == LCDH_ICON_ROW) begin
      ram_row = LCDH_ICON_ROW;
    end else begin
      ram_row = {1'b0, 6'(row_map[5:0] + r.start)};
    end
    ram_col   = r.seg_remap ? 8'(LCDH_COL_LAST - r.scan_col) : r.scan_col;
    scan_byte = ram[ram_idx(ram_row[6:3], ram_col)];
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r  = r;
    wr_en   = 1'b0;
    wr_a    = 11'h000;
    wr_data = 8'h00;
    rd_done = 1'b0;
    byte_ok = 1'b0;
    byte_dc = 1'b0;
    byte_v  = 8'h00;
    sel_now = !r.s2.csl && r.s2.csh;
    sel_prv = !r.s3.csl && r.s3.csh;
    if (i_ce) begin
      next_r.s1    = pins;
      next_r.s2    = r.s1;
      next_r.s3    = r.s2;
      next_r.d_oe  = 1'b0;
      next_r.frame = 1'b0;
      unique case (r.s2.mode)
        LCDH_M6800: begin
          if (sel_now && r.s2.e && r.s2.rw) begin
            next_r.d_oe = 1'b1;
          end
          if (sel_prv && r.s3.e && !r.s2.e) begin
            if (r.s3.rw) begin
              rd_done = r.s3.dc;
            end else begin
              byte_ok = 1'b1;
              byte_dc = r.s3.dc;
              byte_v  = r.s3.d;
            end
          end
        end
        LCDH_M8080: begin
          // read strobe low drives the lines
          if (sel_now && !r.s2.e) begin
            next_r.d_oe = 1'b1;
          end
          if (sel_prv && !r.s3.e && r.s2.e) begin
            rd_done = r.s3.dc;
          end
          if (sel_prv && !r.s3.rw && r.s2.rw) begin
            byte_ok = 1'b1;
            byte_dc = r.s3.dc;
            byte_v  = r.s3.d;
          end
        end
        default: begin
          if (!sel_now) begin
            next_r.bitcnt = 3'h0;
          end else if (!r.s3.d[6] && r.s2.d[6]) begin
            next_r.sh     = {r.sh[6:0], r.s2.d[7]};
            next_r.bitcnt = 3'(r.bitcnt + 3'h1);
            if (r.bitcnt == 3'h7) begin
              byte_ok = 1'b1;
              byte_dc = r.s2.dc;
              byte_v  = {r.sh[6:0], r.s2.d[7]};
            end
          end
        end
      endcase

      // select picks RAM latch or status
      next_r.d_out = r.s2.dc ? r.rd_lat : {1'b0, r.seg_remap, !r.disp_on, 5'h00};

      if (rd_done) begin
        next_r.rd_lat = ram[ram_idx(r.page, r.col)];
        if (!r.rmw) begin
          next_r.col = col_inc(r.col);
        end
      end

      if (byte_ok && byte_dc) begin
        wr_en   = r.col <= LCDH_COL_LAST;
        wr_a    = ram_idx(r.page, r.col);
        wr_data = byte_v;
        next_r.col = col_inc(r.col);
      end else if (byte_ok) begin
        casez (byte_v)
          LCDH_CMD_COL_LO:  next_r.col       = {r.col[7:4], byte_v[3:0]};
          LCDH_CMD_COL_HI:  next_r.col       = {byte_v[3:0], r.col[3:0]};
          LCDH_CMD_START:   next_r.start     = byte_v[5:0];
          LCDH_CMD_SEG_MAP: next_r.seg_remap = byte_v[0];
          LCDH_CMD_REVERSE: next_r.reverse   = byte_v[0];
          LCDH_CMD_DISP_ON: next_r.disp_on   = byte_v[0];
          LCDH_CMD_PAGE: begin
            if (byte_v[3:0] <= LCDH_PAGE_MAX) begin
              next_r.page = byte_v[3:0];
            end
          end
          LCDH_CMD_COM_DIR: next_r.com_remap = byte_v[3];
          LCDH_CMD_RMW: begin
            next_r.rmw      = 1'b1;
            next_r.col_save = r.col;
          end
          LCDH_CMD_RMW_END: begin
            next_r.rmw = 1'b0;
            next_r.col = r.col_save;
          end
          LCDH_CMD_SW_RST: begin
            next_r.rmw   = 1'b0;
            next_r.col   = LCDH_COL_RST;
            next_r.page  = LCDH_PAGE_RST;
            next_r.start = LCDH_START_RST;
          end
          default: ;
        endcase
      end

      // scan timing and converter clock from own clock
      next_r.div      = LCDH_CONV_DIV_W'(r.div + 1'b1);
      next_r.scan_col = col_inc(r.scan_col);
      if (r.scan_col == LCDH_COL_LAST) begin
        if (r.scan_row == LCDH_ICON_ROW) begin
          next_r.scan_row = 7'h00;
          next_r.frame    = 1'b1;
        end else begin
          next_r.scan_row = 7'(r.scan_row + 7'h01);
        end
      end
      next_r.seg_col = r.scan_col;
      next_r.com_row = r.scan_row;
      next_r.seg_bit = r.disp_on && (scan_byte[ram_row[2:0]] ^ r.reverse);
      // rows past the ratio not selected, icon row excepted
      next_r.com_nonsel = (r.scan_row != LCDH_ICON_ROW) && (r.scan_row >= 7'(MUX_RATIO));
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // reset clears shifter, column, page
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ce && wr_en) begin
      ram[wr_a] <= wr_data;
    end
  end

  assign bus.dev_d    = r.d_out;
  assign bus.dev_d_oe = r.d_oe;
  assign o_seg_col    = r.seg_col;
  assign o_seg_bit    = r.seg_bit;
  assign o_com_row    = r.com_row;
  assign o_com_nonsel = r.com_nonsel;
  assign o_frame      = r.frame;
  assign o_conv_clk   = r.div[LCDH_CONV_DIV_W-1];
  assign o_rmw        = r.rmw;

endmodule : lcdh_dev
`default_nettype wire

// [rtl/lcdh_host.sv]
// Microcontroller end: drives 6800, 8080 or serial transfers onto the link
`timescale 1ns/100ps
`default_nettype none
module lcdh_host
  import lcdh_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_req,
  input  wire logic       i_dc,
  input  wire logic       i_rnw,
  input  wire logic [7:0] i_wdata,
  lcdh_if.host            bus,
  output logic            o_busy,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_SETUP = 5'h02,
    H_STRB  = 5'h04,
    H_HOLD  = 5'h08,
    H_SER   = 5'h10
  } lcdh_hst_st_t;

  typedef struct packed {
    lcdh_hst_st_t st;
    logic [7:0]   cnt;
    logic [2:0]   bitn;
    logic [7:0]   sh;
    logic         dc;
    logic         rnw;
    logic         need_dummy;
    logic         dummy;
    logic [7:0]   s1;
    logic [7:0]   s2;
    logic [1:0]   mode;
    logic         csl;
    logic         csh;
    logic         dco;
    logic         rw;
    logic         e;
    logic [7:0]   d;
    logic         doe;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         busy;
  } lcdh_hst_t;

  localparam lcdh_hst_t H_RST = '{st: H_IDLE, csl: 1'b1, rw: 1'b1, need_dummy: 1'b1,
                                  default: '0};
  localparam logic [7:0] STRB_LAST = 8'(LCDH_STROBE_CYC - 1);
  localparam logic [7:0] SCK_HALF  = 8'(LCDH_SCK_HALF);
  localparam logic [7:0] SCK_LAST  = 8'(2 * LCDH_SCK_HALF - 1);

  lcdh_hst_t r;
  lcdh_hst_t next_r;

  always_comb begin
    next_r = r;
    if (i_ce) begin
      next_r.s1     = bus.bus_d;
      next_r.s2     = r.s1;
      next_r.rvalid = 1'b0;
      next_r.cnt    = 8'(r.cnt + 8'h01);
      unique case (r.st)
        H_IDLE: begin
          next_r.mode = i_mode;
          next_r.e    = (i_mode == LCDH_M8080);
          next_r.rw   = 1'b1;
          next_r.cnt  = 8'h00;
          if (i_req) begin
            next_r.busy = 1'b1;
            next_r.dc   = i_dc;
            next_r.rnw  = i_rnw && (i_mode != LCDH_MSER);
            next_r.sh   = i_wdata;
            next_r.dummy = i_rnw && i_dc && r.need_dummy && (i_mode != LCDH_MSER);
            next_r.st    = H_SETUP;
          end
        end
        H_SETUP: begin
          next_r.csl = 1'b0;
          next_r.csh = 1'b1;
          next_r.dco = r.dc;
          next_r.rw  = (r.mode == LCDH_M6800) ? r.rnw : 1'b1;
          next_r.d   = (r.mode == LCDH_MSER) ? {r.sh[7], 7'h00} : r.sh;
          next_r.doe = !r.rnw;
          if (r.cnt == STRB_LAST) begin
            next_r.cnt = 8'h00;
            next_r.st  = (r.mode == LCDH_MSER) ? H_SER : H_STRB;
          end
        end
        H_STRB: begin
          if (r.mode == LCDH_M6800) begin
            next_r.e = 1'b1;
          end else if (r.rnw) begin
            next_r.e = 1'b0;
          end else begin
            next_r.rw = 1'b0;
          end
          if (r.cnt == STRB_LAST) begin
            next_r.cnt = 8'h00;
            next_r.st  = H_HOLD;
            next_r.e   = (r.mode == LCDH_M8080);
            next_r.rw  = (r.mode == LCDH_M6800) ? r.rnw : 1'b1;
            if (r.rnw && !r.dummy) begin
              next_r.rdata = r.s2;
            end
          end
        end
        H_SER: begin
          // clock on line six, data seven
          next_r.d = {r.sh[7], r.cnt >= SCK_HALF, 6'h00};
          if (r.cnt == SCK_LAST) begin
            next_r.cnt  = 8'h00;
            next_r.sh   = {r.sh[6:0], 1'b0};
            next_r.bitn = 3'(r.bitn + 3'h1);
            if (r.bitn == 3'h7) begin
              next_r.st = H_HOLD;
            end
          end
        end
        H_HOLD: begin
          next_r.d = (r.mode == LCDH_MSER) ? 8'h00 : r.d;
          if (r.cnt == STRB_LAST) begin
            next_r.cnt = 8'h00;
            next_r.csl = 1'b1;
            next_r.csh = 1'b0;
            next_r.doe = 1'b0;
            if (r.dummy) begin
              next_r.dummy      = 1'b0;
              next_r.need_dummy = 1'b0;
              next_r.st         = H_SETUP;
            end else begin
              next_r.st     = H_IDLE;
              next_r.busy   = 1'b0;
              next_r.rvalid = r.rnw;
              if (!r.rnw) begin
                next_r.need_dummy = 1'b1;
              end else if (r.dc) begin
                next_r.need_dummy = 1'b0;
              end
            end
          end
        end
        default: next_r = H_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r <= H_RST;
    end else begin
      r <= next_r;
    end
  end

  assign bus.mode                    = r.mode;
  assign bus.chip_select_active_low  = r.csl;
  assign bus.chip_select_active_high = r.csh;
  assign bus.dc                      = r.dco;
  assign bus.rw_wr                   = r.rw;
  assign bus.e_rd                    = r.e;
  assign bus.host_d                  = r.d;
  assign bus.host_d_oe               = r.doe;
  assign o_busy                      = r.busy;
  assign o_rdata                     = r.rdata;
  assign o_rvalid                    = r.rvalid;

endmodule : lcdh_host
`default_nettype wire

// [verif/lcdh_props.sv]
// Concurrent checks on the host-to-display link and scan outputs
`timescale 1ns/100ps
`default_nettype none
module lcdh_props
  import lcdh_pkg::*;
#(
  parameter int MUX_RATIO = LCDH_MUX_POR
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic [1:0] mode,
  input  wire logic       chip_select_active_low,
  input  wire logic       chip_select_active_high,
  input  wire logic       dc,
  input  wire logic       rw_wr,
  input  wire logic       e_rd,
  input  wire logic [7:0] host_d,
  input  wire logic       host_d_oe,
  input  wire logic       dev_d_oe,
  input  wire logic [6:0] o_com_row,
  input  wire logic       o_com_nonsel,
  input  wire logic       o_conv_clk,
  input  wire logic [7:0] o_seg_col,
  input  wire logic       o_frame
);
  logic [3:0] sck_cnt;
  logic       sck_q;
  logic       sel;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  assign sel = !chip_select_active_low && chip_select_active_high;

  // Serial clock rises seen within one select window
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sck_cnt <= 4'h0;
      sck_q   <= 1'b0;
    end else begin
      sck_q <= host_d[6];
      if (!sel) begin
        sck_cnt <= 4'h0;
      end else if (host_d_oe && host_d[6] && !sck_q) begin
        sck_cnt <= sck_cnt + 4'h1;
      end
    end
  end

  sequence s_conv_high;
    o_conv_clk [*8];
  endsequence
  sequence s_ser_end;
    $rose(chip_select_active_low) && mode == LCDH_MSER;
  endsequence

  property p_conv_div;
    $rose(o_conv_clk) |-> s_conv_high ##1 !o_conv_clk;
  endproperty
  property p_ser_bits;
    s_ser_end |-> sck_cnt == 4'h8;
  endproperty
  property p_ser_dc;
    mode == LCDH_MSER && sel && host_d_oe && $rose(host_d[6]) |-> $stable(dc);
  endproperty
  property p_oe_sel;
    dev_d_oe |-> sel;
  endproperty
  property p_no_fight;
    !(dev_d_oe && host_d_oe);
  endproperty
  property p_rd6800;
    $rose(dev_d_oe) && mode == LCDH_M6800 |-> rw_wr && e_rd;
  endproperty
  property p_rd8080;
    $rose(dev_d_oe) && mode == LCDH_M8080 |-> rw_wr && !e_rd;
  endproperty
  property p_ser_wo;
    mode == LCDH_MSER |-> !dev_d_oe;
  endproperty
  property p_wr6800;
    mode == LCDH_M6800 && sel && e_rd && !rw_wr |-> host_d_oe && $stable(host_d);
  endproperty
  property p_wr8080;
    mode == LCDH_M8080 && sel && !rw_wr |-> host_d_oe && $stable(host_d);
  endproperty
  property p_nonsel;
    o_com_nonsel == (o_com_row >= MUX_RATIO && o_com_row != LCDH_ICON_ROW);
  endproperty
  property p_frame;
    o_frame |-> o_com_row == LCDH_ICON_ROW && o_seg_col == LCDH_COL_LAST;
  endproperty

  a_conv_div: assert property (p_conv_div)
    else $error("converter clock not a divide by 16");
  a_ser_bits: assert property (p_ser_bits)
    else $error("serial frame without eight clock rises");
  a_ser_dc: assert property (p_ser_dc)
    else $error("select line moved at a serial clock rise");
  a_oe_sel: assert property (p_oe_sel)
    else $error("device drives data while not selected");
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive the data lines");
  a_rd6800: assert property (p_rd6800)
    else $error("6800 read data without read phase");
  a_rd8080: assert property (p_rd8080)
    else $error("8080 read data without read strobe");
  a_ser_wo: assert property (p_ser_wo)
    else $error("device drives data in serial mode");
  a_wr6800: assert property (p_wr6800)
    else $error("6800 write data not held under enable");
  a_wr8080: assert property (p_wr8080)
    else $error("8080 write data not held under strobe");
  a_nonsel: assert property (p_nonsel)
    else $error("non-select flag wrong for scanned row");
  a_frame: assert property (p_frame)
    else $error("frame pulse not after last column of icon row");
endmodule : lcdh_props
`default_nettype wire

// [verif/tb_lcd_host_interface_decoder.sv]
// Self-checking bench joining the host end to the display end
`timescale 1ns/100ps
`default_nettype none
module tb_lcd_host_interface_decoder
  import lcdh_pkg::*;
();
  localparam int MUX = 48;
  logic       mclk       = 1'b0;
  logic       rst        = 1'b1;
  logic [1:0] h_mode     = 2'h0;
  logic       h_req      = 1'b0;
  logic       h_dc       = 1'b0;
  logic       h_rnw      = 1'b0;
  logic [7:0] h_wdata    = 8'h00;
  logic       h_busy;
  logic       h_rvalid;
  logic [7:0] h_rdata;
  logic [6:0] d_row;
  logic       d_nonsel;
  logic       d_conv;
  logic       d_rmw;
  logic [7:0] d_col;
  logic       d_seg;
  logic       d_frame;
  int         errors     = 0;
  int         n_compared = 0;

  lcdh_if link ();

  always #2.5 mclk = ~mclk;

  lcdh_host u_lcdh_host (.i_mclk(mclk), .i_rst(rst), .i_ce(1'b1), .i_mode(h_mode),
    .i_req(h_req), .i_dc(h_dc), .i_rnw(h_rnw), .i_wdata(h_wdata), .bus(link.host),
    .o_busy(h_busy), .o_rdata(h_rdata), .o_rvalid(h_rvalid));
  lcdh_dev #(.MUX_RATIO(MUX)) u_lcdh_dev (.i_mclk(mclk), .i_rst(rst), .i_ce(1'b1),
    .bus(link.dev), .o_seg_col(d_col), .o_seg_bit(d_seg), .o_com_row(d_row),
    .o_com_nonsel(d_nonsel), .o_frame(d_frame), .o_conv_clk(d_conv), .o_rmw(d_rmw));
  lcdh_props #(.MUX_RATIO(MUX)) u_lcdh_props (.i_mclk(mclk), .i_rst(rst),
    .mode(link.mode), .chip_select_active_low(link.chip_select_active_low),
    .chip_select_active_high(link.chip_select_active_high), .dc(link.dc),
    .rw_wr(link.rw_wr), .e_rd(link.e_rd), .host_d(link.host_d),
    .host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe), .o_com_row(d_row),
    .o_com_nonsel(d_nonsel), .o_conv_clk(d_conv), .o_seg_col(d_col), .o_frame(d_frame));

  function automatic logic [7:0] exp_status(input logic remap, input logic off);
    return {1'b0, remap, off, 5'h00};
  endfunction : exp_status

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic xfer(input logic [1:0] m, input logic dc, input logic rnw,
                      input logic [7:0] wd);
    int n;
    @(negedge mclk);
    h_mode  = m;
    h_dc    = dc;
    h_rnw   = rnw;
    h_wdata = wd;
    h_req   = 1'b1;
    @(negedge mclk);
    h_req = 1'b0;
    n = 0;
    while (h_busy !== 1'b0 && n < 600) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 600) begin
      errors++;
      $display("unexpected at %0t: transfer never ended", $time);
    end
  endtask : xfer

  task automatic cmd(input logic [1:0] m, input logic [7:0] c);
    xfer(m, 1'b0, 1'b0, c);
  endtask : cmd

  task automatic wr(input logic [1:0] m, input logic [7:0] d);
    xfer(m, 1'b1, 1'b0, d);
  endtask : wr

  task automatic set_col(input logic [1:0] m, input logic [7:0] c);
    cmd(m, {4'h1, c[7:4]});
    cmd(m, {4'h0, c[3:0]});
  endtask : set_col

  task automatic rd(input logic [1:0] m, input logic dc, input logic [7:0] e);
    xfer(m, dc, 1'b1, 8'h00);
    check(h_rdata, e);
    check({7'h00, h_rvalid}, 8'h01);
  endtask : rd

  initial begin
    #300000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    logic [3:0] pg;
    logic [7:0] col;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    int         nf;
    void'($urandom(32'hFB16042F));
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    rd(2'h0, 1'b0, exp_status(1'b0, 1'b1));
    rd(2'h1, 1'b0, exp_status(1'b0, 1'b1));
    cmd(2'h2, 8'hA1);
    rd(2'h0, 1'b0, exp_status(1'b1, 1'b1));
    cmd(2'h0, 8'hAF);
    rd(2'h1, 1'b0, exp_status(1'b1, 1'b0));
    cmd(2'h1, 8'hA0);
    rd(2'h0, 1'b0, exp_status(1'b0, 1'b0));
    $display("status test done");
    for (int wm = 0; wm < 3; wm++) begin
      for (int rm = 0; rm < 2; rm++) begin
        pg  = 4'($urandom_range(8, 0));
        col = 8'($urandom_range(130, 0));
        a   = 8'($urandom);
        b   = 8'($urandom);
        cmd(2'(wm), {4'hB, pg});
        set_col(2'(wm), col);
        wr(2'(wm), a);
        wr(2'(wm), b);
        cmd(2'(rm), 8'hB9);
        set_col(2'(rm), col);
        rd(2'(rm), 1'b1, a);
        rd(2'(rm), 1'b1, b);
      end
    end
    $display("mode cross test done");
    set_col(2'h0, LCDH_COL_LAST);
    wr(2'h0, a);
    wr(2'h0, b);
    set_col(2'h1, LCDH_COL_LAST);
    rd(2'h1, 1'b1, a);
    rd(2'h1, 1'b1, b);
    $display("column wrap test done");
    col = 8'($urandom_range(120, 0));
    c   = ~a;
    set_col(2'h1, col);
    cmd(2'h1, LCDH_CMD_RMW);
    check({7'h00, d_rmw}, 8'h01);
    wr(2'h1, a);
    wr(2'h1, b);
    cmd(2'h2, LCDH_CMD_RMW_END);
    check({7'h00, d_rmw}, 8'h00);
    wr(2'h2, c);
    set_col(2'h0, col);
    rd(2'h0, 1'b1, c);
    rd(2'h0, 1'b1, b);
    set_col(2'h0, col);
    cmd(2'h0, LCDH_CMD_RMW);
    rd(2'h0, 1'b1, c);
    rd(2'h0, 1'b1, c);
    cmd(2'h0, LCDH_CMD_RMW_END);
    $display("read-modify-write test done");
    cmd(2'h0, 8'hB3);
    set_col(2'h0, 8'h05);
    cmd(2'h0, LCDH_CMD_SW_RST);
    wr(2'h0, c);
    cmd(2'h1, 8'hB0);
    set_col(2'h1, LCDH_COL_RST);
    rd(2'h1, 1'b1, c);
    $display("soft reset test done");
    cmd(2'h0, 8'hB3);
    set_col(2'h0, 8'h07);
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    wr(2'h0, a);
    cmd(2'h1, 8'hB0);
    set_col(2'h1, LCDH_COL_RST);
    rd(2'h1, 1'b1, a);
    nf = 0;
    repeat (2 * LCDH_COLS * LCDH_ROWS) begin
      @(negedge mclk);
      nf += int'(d_frame);
    end
    check(8'(nf), 8'h02);
    check({7'h00, d_seg}, 8'h00);
    $display("reset and scan test done");
    complete_run();
  end
endmodule : tb_lcd_host_interface_decoder
`default_nettype wire
